// ### ppd_control.sv
`timescale 1ns/10ps
// ****************************************************************
// pin power-down control
// ****************************************************************

// What this block does
// - power-down only acts when the configuration enable is set
// - while powered down, outputs and internal state are held
// - outputs disabled at power-down entry stay disabled throughout
// - while powered down all inputs except the power-down pin are blocked
// - pin keepers stay active while powered down, holding last levels
// - power-down pin macrocell feedback and foldback stay usable
// - outputs valid again at most 2 us after pin release
// - inputs, enables, clocks valid within 2 us of release
// - two power-down pins, either one can request power-down
module ppd_control (
   // clock and reset
   input  wire logic                          sys_clk,
   input  wire logic                          sys_rst,
   // configuration
   input  wire logic                          pd_enable,
   input  wire logic [ppd_pkg::N_PD-1:0]      power_down_pin,
   // pins toward the array
   input  wire logic [ppd_pkg::N_PINS-1:0]    pin_in,
   // array side
   input  wire ppd_pkg::ppd_io_s              array_out,
   input  wire logic [ppd_pkg::N_PD-1:0]      pd_mc_feedback,
   output ppd_pkg::ppd_io_s                   pad_out,
   output logic [ppd_pkg::N_PINS-1:0]         array_in,
   output logic [ppd_pkg::N_PD-1:0]           pd_mc_fb_out,
   output logic                               array_clk_en,
   output logic                               keeper_en,
   output logic                               powered_down
);

   // ****************************************************************
   // state
   // ****************************************************************
   ppd_pkg::ppd_state_e               st_q;
   ppd_pkg::ppd_state_e               st_d;
   ppd_pkg::ppd_io_s                  pad_q;
   ppd_pkg::ppd_io_s                  pad_d;
   logic [ppd_pkg::N_PINS-1:0]        in_q;
   logic [ppd_pkg::N_PINS-1:0]        in_d;
   logic [ppd_pkg::N_PD-1:0]          fb_q;
   logic [ppd_pkg::N_PD-1:0]          fb_d;
   logic                              clk_en_q;
   logic                              clk_en_d;
   logic                              keep_q;
   logic                              keep_d;
   logic                              down_q;
   logic                              down_d;
   logic                              pd_req;
   logic                              rec_start;
   logic                              rec_done;

   // either pin asks for power-down, only when the feature is enabled
   assign pd_req = pd_enable & (|power_down_pin);

   // ****************************************************************
   // sequencer
   // ****************************************************************

   // a new request during recovery returns straight to held state
   always_comb begin
      st_d      = st_q;
      rec_start = 1'b0;
      unique case (st_q)
         ppd_pkg::PPD_RUN: begin
            if (pd_req) begin
               st_d = ppd_pkg::PPD_DOWN;
            end
         end
         ppd_pkg::PPD_DOWN: begin
            if (!pd_req) begin
               st_d      = ppd_pkg::PPD_RECOVER;
               rec_start = 1'b1;
            end
         end
         ppd_pkg::PPD_RECOVER: begin
            if (pd_req) begin
               st_d = ppd_pkg::PPD_DOWN;
            end else if (rec_done) begin
               st_d = ppd_pkg::PPD_RUN;
            end
         end
      endcase
   end

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         st_q <= ppd_pkg::PPD_RUN;
      end else begin
         st_q <= st_d;
      end
   end

   // recovery counter, cleared if power-down comes back mid recovery
   ppd_recover_timer u_timer (
      .sys_clk (sys_clk),
      .sys_rst (sys_rst),
      .start   (rec_start),
      .clear   (pd_req),
      .done    (rec_done)
   );

   // ****************************************************************
   // pin datapath
   // ****************************************************************

   // held while down or recovering; recovery stays held so no glitch
   // reaches the pins before the input path has settled again
   always_comb begin
      pad_d    = pad_q;
      in_d     = in_q;
      clk_en_d = 1'b0;
      keep_d   = 1'b1;
      down_d   = 1'b1;
      // feedback of the power-down macrocell always passes
      fb_d     = pd_mc_feedback;
      if (st_d == ppd_pkg::PPD_RUN) begin
         pad_d    = array_out;
         in_d     = pin_in;
         clk_en_d = 1'b1;
         keep_d   = 1'b0;
         down_d   = 1'b0;
      end
      // else: pad_q keeps data and oe, high-z stays high-z
      // else: pin_in ignored, clocks frozen
      // else: keepers enabled
   end

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         pad_q    <= '0;
         in_q     <= ppd_pkg::PINS_RST;
         fb_q     <= '0;
         clk_en_q <= 1'b1;
         keep_q   <= 1'b0;
         down_q   <= 1'b0;
      end else begin
         pad_q    <= pad_d;
         in_q     <= in_d;
         fb_q     <= fb_d;
         clk_en_q <= clk_en_d;
         keep_q   <= keep_d;
         down_q   <= down_d;
      end
   end

   // outputs straight from flops
   assign pad_out      = pad_q;
   assign array_in     = in_q;
   assign pd_mc_fb_out = fb_q;
   assign array_clk_en = clk_en_q;
   assign keeper_en    = keep_q;
   assign powered_down = down_q;

   // ****************************************************************
   // checks
   // ****************************************************************
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (sys_rst);

   // cycles held since the pins were last released; a new request restarts
   // it, so a legal re-request during recovery cannot trip the limit below
   logic [ppd_pkg::CNT_W-1:0]         rel_cnt_q;
   logic [ppd_pkg::CNT_W-1:0]         rel_cnt_d;

   // saturate so a stuck sequencer cannot wrap back under the limit
   always_comb begin
      rel_cnt_d = rel_cnt_q;
      if (pd_req || !powered_down) begin
         rel_cnt_d = ppd_pkg::CNT_RST;
      end else if (rel_cnt_q != '1) begin
         rel_cnt_d = rel_cnt_q + ppd_pkg::CNT_W'(1);
      end
   end

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         rel_cnt_q <= ppd_pkg::CNT_RST;
      end else begin
         rel_cnt_q <= rel_cnt_d;
      end
   end

   AST_DISABLED_PASS: assert property (
      !pd_enable |=> !powered_down)
      else $error("power-down while feature disabled");

   AST_HOLD_OUT: assert property (
      powered_down && $past(powered_down) |-> $stable(pad_out.data))
      else $error("output data changed while held");

   AST_HIZ_STAYS: assert property (
      powered_down && $past(powered_down) |-> $stable(pad_out.oe))
      else $error("output enable changed while held");

   AST_INPUT_BLOCK: assert property (
      powered_down && $past(powered_down) |-> $stable(array_in) && !array_clk_en)
      else $error("input reached array while held");

   AST_KEEPER: assert property (
      st_q != ppd_pkg::PPD_RUN |-> keeper_en && powered_down && !array_clk_en)
      else $error("keeper off while powered down");

   AST_FB_PASS: assert property (
      1'b1 |=> pd_mc_fb_out == $past(pd_mc_feedback))
      else $error("macrocell feedback blocked");

   AST_ENTER: assert property (
      pd_enable && |power_down_pin && !powered_down |=> powered_down)
      else $error("power-down not entered");

   // the release edge itself is counted too, hence one above the cycle count
   AST_RECOVER_MAX: assert property (
      rel_cnt_q <= ppd_pkg::CNT_W'(ppd_pkg::RECOVER_CYC + 1))
      else $error("recovery exceeded 2 us");

   AST_RECOVER_IN: assert property (
      $fell(powered_down) |-> array_clk_en && !keeper_en)
      else $error("inputs not restored with outputs");

   AST_RUN_PASS: assert property (
      !pd_req && !powered_down && st_q == ppd_pkg::PPD_RUN |=> array_in == $past(pin_in))
      else $error("input not passed in normal operation");

   COV_DOWN:    cover property (pd_req ##1 powered_down);
   COV_RECOVER: cover property ($fell(powered_down));
   COV_REENTER: cover property (st_q == ppd_pkg::PPD_RECOVER ##1 st_q == ppd_pkg::PPD_DOWN);

endmodule // ppd_control

// ### ppd_pkg.sv
// ****************************************************************
// power-down control package
// ****************************************************************
package ppd_pkg;

   // clock rate and recovery timing
   localparam int unsigned CLK_PERIOD_NS = 100;
   localparam int unsigned RECOVER_US    = 2;
   // longest time: round down, at least one cycle
   localparam int unsigned RECOVER_CYC_RAW = (RECOVER_US * 1000) / CLK_PERIOD_NS;
   localparam int unsigned RECOVER_CYC     = (RECOVER_CYC_RAW < 1) ? 1 : RECOVER_CYC_RAW;
   localparam int unsigned CNT_W           = 5;
   localparam logic [CNT_W-1:0] CNT_RST    = 5'h00;

   // pin counts and widths
   localparam int unsigned N_PINS = 8;
   localparam int unsigned N_PD   = 2;

   // reset values
   localparam logic [N_PINS-1:0] PINS_RST = 8'h00;

   // operating state of the power-down sequencer
   typedef enum logic [1:0] {
      PPD_RUN,
      PPD_DOWN,
      PPD_RECOVER
   } ppd_state_e;

   // one i/o pin group as seen by the array
   typedef struct packed {
      logic [N_PINS-1:0] data;
      logic [N_PINS-1:0] oe;
   } ppd_io_s;

endpackage

// ### ppd_recover_timer.sv
`timescale 1ns/10ps
// ****************************************************************
// recovery timer: counts cycles after power-down release
// ****************************************************************
module ppd_recover_timer (
   // clock and reset
   input  wire logic                      sys_clk,
   input  wire logic                      sys_rst,
   // control
   input  wire logic                      start,
   input  wire logic                      clear,
   // status
   output logic                           done
);

   logic [ppd_pkg::CNT_W-1:0] cnt_q;
   logic [ppd_pkg::CNT_W-1:0] cnt_d;
   logic                      run_q;
   logic                      run_d;

   // next count; done pulses on the last recovery cycle
   always_comb begin
      cnt_d = cnt_q;
      run_d = run_q;
      done  = 1'b0;
      if (clear) begin
         cnt_d = ppd_pkg::CNT_RST;
         run_d = 1'b0;
      end else if (start) begin
         cnt_d = ppd_pkg::CNT_RST;
         run_d = 1'b1;
      end else if (run_q) begin
         if (cnt_q == ppd_pkg::CNT_W'(ppd_pkg::RECOVER_CYC - 1)) begin
            done  = 1'b1;
            run_d = 1'b0;
         end else begin
            cnt_d = cnt_q + ppd_pkg::CNT_W'(1);
         end
      end
   end

   // register the counter
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         cnt_q <= ppd_pkg::CNT_RST;
         run_q <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         run_q <= run_d;
      end
   end

endmodule // ppd_recover_timer

// ### ppd_sys_model.sv
`timescale 1ns/10ps
// ******************
// power-down driver
// ******************
module ppd_sys_model (
   // clock
   input  wire logic       sys_clk,
   // bench requests
   input  wire logic [1:0] req,
   input  wire logic       slow,
   input  wire logic       powered_down,
   // toward device
   output logic [1:0]      power_down_pin = 2'b00,
   output logic            sys_ok
);
   logic [1:0] stage_q = 2'b00;

   // pins only reach the control input, never pin_in
   always @(posedge sys_clk) begin
      stage_q <= req;
      power_down_pin <= #1 (slow ? stage_q : req);
   end

   // system logic trusts the device only once recovery ends
   assign sys_ok = !powered_down;
endmodule // ppd_sys_model

// ### testbench.sv
`timescale 1ns/10ps
// ******************
// power-down bench
// ******************
module testbench;
   logic             sys_clk, sys_rst, pd_enable, slow, sys_ok;
   logic [1:0]       req, power_down_pin, pd_mc_feedback, pd_mc_fb_out;
   logic [7:0]       pin_in, array_in;
   ppd_pkg::ppd_io_s array_out, pad_out;
   logic             array_clk_en, keeper_en, powered_down;
   int               err_count = 0;
   int               total_checks = 0;
   int               n;

   ppd_control ppd_control_inst (
      .sys_clk(sys_clk), .sys_rst(sys_rst), .pd_enable(pd_enable),
      .power_down_pin(power_down_pin), .pin_in(pin_in), .array_out(array_out),
      .pd_mc_feedback(pd_mc_feedback), .pad_out(pad_out), .array_in(array_in),
      .pd_mc_fb_out(pd_mc_fb_out), .array_clk_en(array_clk_en),
      .keeper_en(keeper_en), .powered_down(powered_down));

   ppd_sys_model ppd_sys_model_inst (
      .sys_clk(sys_clk), .req(req), .slow(slow), .powered_down(powered_down),
      .power_down_pin(power_down_pin), .sys_ok(sys_ok));

   // 10 MHz clock
   initial begin
      sys_clk = 1'b0;
      forever #50 sys_clk = ~sys_clk;
   end

   // inputs move 1 ns after the edge, clear of sampling
   task automatic step(input int k);
      repeat (k) @(posedge sys_clk);
      #1;
   endtask

   task automatic chk(input string nm, input logic [15:0] seen, exp);
      total_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic print_verdict;
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask

   // feature off: pins high must not freeze anything
   task automatic t_disabled;
      pd_enable = 1'b0;
      req = 2'b11;
      step(4);
      pin_in = 8'h3c;
      step(2);
      chk("pd_off", 16'(powered_down), 16'h0000);
      chk("pass", 16'(array_in), 16'h003c);
      req = 2'b00;
      step(3);
      pd_enable = 1'b1;
      $display("test disabled done");
   endtask

   task automatic enter(input logic [1:0] mask);
      pin_in = 8'h5a;
      array_out = 16'hc30f;
      step(2);
      chk("pass_in", 16'(array_in), 16'h005a);
      chk("pass_out", pad_out, 16'hc30f);
      req = mask;
      step(5);
      chk("state", {13'h0, powered_down, keeper_en, array_clk_en}, 16'h0006);
   endtask

   // release and count cycles until the device is usable again
   task automatic recover(input int lim);
      req = 2'b00;
      n = 0;
      while (sys_ok !== 1'b1 && n < 40) begin
         step(1);
         n++;
      end
      chk("recov_min", 16'(n >= ppd_pkg::RECOVER_CYC), 16'h0001);
      chk("recov_max", 16'(n <= lim), 16'h0001);
   endtask

   // freeze, disturb every input, then release
   task automatic t_hold(input logic [1:0] mask, input logic slw);
      slow = slw;
      enter(mask);
      pin_in = 8'ha5;
      array_out = 16'h3cff;
      pd_mc_feedback = 2'b10;
      step(3);
      chk("held_in", 16'(array_in), 16'h005a);
      chk("held_out", pad_out, 16'hc30f);
      chk("fb", 16'(pd_mc_fb_out), 16'h0002);
      recover(ppd_pkg::RECOVER_CYC + 3 + 32'(slw));
      chk("res_in", 16'(array_in), 16'h00a5);
      chk("res_out", pad_out, 16'h3cff);
      chk("run", {14'h0, keeper_en, array_clk_en}, 16'h0001);
      pd_mc_feedback = 2'b01;
      $display("test hold %b done", mask);
   endtask

   // a new request mid-recovery must restart the timer
   task automatic t_rereq;
      slow = 1'b0;
      enter(2'b01);
      req = 2'b00;
      step(8);
      req = 2'b01;
      step(3);
      chk("rereq", 16'(powered_down), 16'h0001);
      recover(ppd_pkg::RECOVER_CYC + 3);
      $display("test rerequest done");
   endtask

   // ******************
   // main sequence
   // ******************
   initial begin
      sys_rst = 1'b1;
      pd_enable = 1'b1;
      slow = 1'b0;
      req = 2'b00;
      pin_in = 8'h00;
      array_out = 16'h0000;
      pd_mc_feedback = 2'b00;
      step(4);
      chk("rst", {13'h0, powered_down, keeper_en, array_clk_en}, 16'h0001);
      chk("rst_pad", pad_out, 16'h0000);
      sys_rst = 1'b0;
      step(2);
      t_disabled();
      t_hold(2'b01, 1'b0);
      t_hold(2'b10, 1'b1);
      t_rereq();
      print_verdict();
   end

   // the run needs some 120 cycles; 2000 means a hang
   initial begin
      #200000;
      err_count++;
      print_verdict();
   end
endmodule // testbench
